/* hw/dxd_top.sv */
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "dxd_defines.svh"

// Behaviour
// - Protection ranges may cover any target address.
// - Unmatched addresses default to read-write.
// - Sixteen fixed comparison blocks check protection.
// - Beyond sixteen ranges software must free blocks.
// - Ranges load automatically or per entry; here only per entry, by APB writes.
// - Each entry: start, end, one attribute.
// - Each event: warning, breakpoint selectable; trace selectable for all but trace memory overflow.
// - Read of never-written location flags error.
// - Thirty-two monitor blocks, sixteen kilobytes total.
// - Uninit check only in enabled monitor blocks.
// - Flag either stack pointer outside its range.
// - Check on interrupt, call, return, excursion.
// - Only pointer excursions, not stack data.
// - Stack check idle until program downloaded.
// - Section timer overflow flags error, marks result.
// - Profile time or pass overflow: one error.
// - Trace memory overflow: warning and breakpoint.
// - OS: write into other task stack flags.
// - Task stack entry: task id plus range.
// - OS: every task dispatch is an event.
// - Word attributes: RW, RO, WO, disabled, OS-only.
// - 40-bit time counter, 16-bit pass counter.
module dxd_top
	import dxd_pkg::*;
(
	input wire logic CLOCK_IN,
	input wire logic RSTN_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire dxd_tacc_s TBUS_IN,
	input wire dxd_addr_t USER_STACK_POINTER_IN,
	input wire dxd_addr_t INTERRUPT_STACK_POINTER_IN,
	input wire dxd_stk_evt_s STACK_EVT_IN,
	input wire logic DISPATCH_IN,
	input wire logic PERF_START_IN,
	input wire logic PERF_RUN_IN,
	input wire logic PROF_RUN_IN,
	input wire logic PROF_PASS_IN,
	input wire logic TRACE_STORE_IN,
	output logic WARN_OUT,
	output logic BRK_COND_OUT,
	output logic TRACE_COND_OUT
);

	function automatic logic in_range(input dxd_addr_t a, input dxd_addr_t lo, input dxd_addr_t hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// Configuration state.
	logic [2:0] ctrl_q, ctrl_d;
	logic [`DXD_NEV-1:0] status_q, status_d;
	logic [`DXD_NEV-1:0] warn_en_q, warn_en_d;
	logic [`DXD_NEV-1:0] brk_en_q, brk_en_d;
	logic [`DXD_NEV-1:0] trace_en_q, trace_en_d;
	dxd_addr_t ustk_lo_q, ustk_lo_d, ustk_hi_q, ustk_hi_d;
	dxd_addr_t istk_lo_q, istk_lo_d, istk_hi_q, istk_hi_d;
	dxd_prot_s prot_q [`DXD_NPROT];
	dxd_prot_s prot_d [`DXD_NPROT];
	dxd_task_s task_q [`DXD_NTASK];
	dxd_task_s task_d [`DXD_NTASK];
	logic [`DXD_NMON-1:0] mon_en_q, mon_en_d;
	dxd_addr_t mon_base_q [`DXD_NMON];
	dxd_addr_t mon_base_d [`DXD_NMON];
	logic [`DXD_MON_WORDS-1:0] written_q [`DXD_NMON];
	logic [`DXD_MON_WORDS-1:0] written_d [`DXD_NMON];

	// Counter state.
	logic [39:0] perf_cnt_q, perf_cnt_d;
	logic perf_mark_q, perf_mark_d;
	logic [39:0] prof_time_q, prof_time_d;
	logic [15:0] prof_pass_q, prof_pass_d;
	logic [21:0] trace_cnt_q, trace_cnt_d;
	logic stk_out_q, stk_out_d;

	// Bus answer state.
	logic [31:0] prdata_q, prdata_d;
	logic pslverr_q, pslverr_d;

	logic setup;
	logic wr_en;
	logic [`DXD_NEV-1:0] ev;
	logic [`DXD_NPROT-1:0] prot_hit, prot_viol;
	logic [`DXD_NMON-1:0] mon_hit, mon_uninit;
	logic [`DXD_NTASK-1:0] task_viol;
	logic usp_out, isp_out, stk_any_out, stk_evt;

	assign setup = PSEL_IN && !PENABLE_IN;
	assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN;
	assign PREADY_OUT = PSEL_IN && PENABLE_IN;
	assign PRDATA_OUT = prdata_q;
	assign PSLVERR_OUT = pslverr_q && PSEL_IN && PENABLE_IN;

	// Every comparator is evaluated in parallel so a violation lines up with its own cycle.
	genvar gi;
	generate
		for (gi = 0; gi < `DXD_NPROT; gi++)
		begin : g_prot
			always_comb
			begin
				prot_hit[gi] = prot_q[gi].en && in_range(TBUS_IN.addr, prot_q[gi].lo, prot_q[gi].hi);
				prot_viol[gi] = 1'b0;
				case (prot_q[gi].attr)
					DXD_ATTR_RO: prot_viol[gi] = TBUS_IN.wr;
					DXD_ATTR_WO: prot_viol[gi] = TBUS_IN.rd || TBUS_IN.fetch;
					DXD_ATTR_DIS: prot_viol[gi] = TBUS_IN.rd || TBUS_IN.wr || TBUS_IN.fetch;
					DXD_ATTR_DIS_OS: prot_viol[gi] = (TBUS_IN.rd || TBUS_IN.wr || TBUS_IN.fetch)
						&& !TBUS_IN.os;
					default: prot_viol[gi] = 1'b0;
				endcase
				prot_viol[gi] = prot_viol[gi] && prot_hit[gi];
			end
		end
		for (gi = 0; gi < `DXD_NMON; gi++)
		begin : g_mon
			always_comb
			begin
				mon_hit[gi] = mon_en_q[gi] && in_range(TBUS_IN.addr, mon_base_q[gi],
					mon_base_q[gi] + `DXD_MON_SPAN);
				mon_uninit[gi] = mon_hit[gi] && TBUS_IN.rd
					&& !written_q[gi][TBUS_IN.addr[`DXD_MON_IDX_MSB:`DXD_MON_IDX_LSB]];
			end
		end
		for (gi = 0; gi < `DXD_NTASK; gi++)
		begin : g_task
			assign task_viol[gi] = task_q[gi].en && TBUS_IN.wr
				&& in_range(TBUS_IN.addr, task_q[gi].lo, task_q[gi].hi)
				&& (task_q[gi].tid != TBUS_IN.task_id);
		end
	endgenerate

	// Only the pointer values are compared; data stored inside a valid stack is never inspected.
	always_comb
	begin
		usp_out = !in_range(USER_STACK_POINTER_IN, ustk_lo_q, ustk_hi_q);
		isp_out = !in_range(INTERRUPT_STACK_POINTER_IN, istk_lo_q, istk_hi_q);
		stk_any_out = ctrl_q[`DXD_CTRL_ARM] && (usp_out || isp_out);
		stk_evt = stk_any_out && ((|STACK_EVT_IN) || !stk_out_q);
		stk_out_d = stk_any_out;
	end

	// Counters and their overflow events.
	always_comb
	begin
		ev = '0;
		perf_cnt_d = perf_cnt_q;
		perf_mark_d = perf_mark_q;
		prof_time_d = prof_time_q;
		prof_pass_d = prof_pass_q;
		trace_cnt_d = trace_cnt_q;
		if (PERF_START_IN)
		begin
			perf_cnt_d = '0;
		end
		else if (PERF_RUN_IN)
		begin
			perf_cnt_d = perf_cnt_q + 40'h1;
			if (perf_cnt_q == `DXD_PERF_MAX)
			begin
				ev[`DXD_EV_PERF] = 1'b1;
				perf_mark_d = 1'b1;
			end
		end
		if (PROF_RUN_IN)
		begin
			prof_time_d = prof_time_q + 40'h1;
		end
		if (PROF_PASS_IN)
		begin
			prof_pass_d = prof_pass_q + 16'h1;
		end
		ev[`DXD_EV_PROF] = (PROF_RUN_IN && prof_time_q == `DXD_PROF_TIME_MAX)
			|| (PROF_PASS_IN && prof_pass_q == `DXD_PROF_PASS_MAX);
		if (TRACE_STORE_IN)
		begin
			trace_cnt_d = trace_cnt_q + 22'h1;
			ev[`DXD_EV_TRACE] = trace_cnt_q == `DXD_TRACE_MAX;
		end
		ev[`DXD_EV_PROT] = |prot_viol;
		ev[`DXD_EV_UNINIT] = |mon_uninit;
		ev[`DXD_EV_STACK] = stk_evt;
		ev[`DXD_EV_TSTACK] = ctrl_q[`DXD_CTRL_OS] && (|task_viol);
		ev[`DXD_EV_DISPATCH] = ctrl_q[`DXD_CTRL_OS] && DISPATCH_IN;
		if (wr_en && PADDR_IN == `DXD_A_PERF && PWDATA_IN[0])
		begin
			perf_mark_d = ev[`DXD_EV_PERF];
		end
	end

	// The conditions leave combinationally so a breakpoint refers to the offending cycle.
	assign BRK_COND_OUT = |(ev & brk_en_q);
	assign TRACE_COND_OUT = |(ev & trace_en_q);
	assign WARN_OUT = |(status_q & warn_en_q);

	// Register writes, sticky flags and written-location tracking.
	always_comb
	begin
		ctrl_d = ctrl_q;
		warn_en_d = warn_en_q;
		brk_en_d = brk_en_q;
		trace_en_d = trace_en_q;
		ustk_lo_d = ustk_lo_q;
		ustk_hi_d = ustk_hi_q;
		istk_lo_d = istk_lo_q;
		istk_hi_d = istk_hi_q;
		prot_d = prot_q;
		task_d = task_q;
		mon_en_d = mon_en_q;
		mon_base_d = mon_base_q;
		written_d = written_q;
		status_d = status_q;
		if (wr_en && PADDR_IN == `DXD_A_STATUS)
		begin
			status_d = status_q & ~PWDATA_IN[`DXD_NEV-1:0];
		end
		status_d = status_d | ev;
		for (int i = 0; i < `DXD_NMON; i++)
		begin
			if (mon_hit[i] && TBUS_IN.wr)
			begin
				written_d[i][TBUS_IN.addr[`DXD_MON_IDX_MSB:`DXD_MON_IDX_LSB]] = 1'b1;
			end
		end
		if (wr_en)
		begin
			if (PADDR_IN == `DXD_A_CTRL)
			begin
				ctrl_d = PWDATA_IN[2:0];
			end
			else if (PADDR_IN == `DXD_A_WARN_EN)
			begin
				warn_en_d = PWDATA_IN[`DXD_NEV-1:0];
			end
			else if (PADDR_IN == `DXD_A_BRK_EN)
			begin
				brk_en_d = PWDATA_IN[`DXD_NEV-1:0];
			end
			else if (PADDR_IN == `DXD_A_TRACE_EN)
			begin
				// Trace memory overflow cannot act as a trace point condition.
				trace_en_d = PWDATA_IN[`DXD_NEV-1:0] & `DXD_TRACE_EN_MASK;
			end
			else if (PADDR_IN == `DXD_A_USTK_LO)
			begin
				ustk_lo_d = PWDATA_IN[`DXD_TADDR_W-1:0];
			end
			else if (PADDR_IN == `DXD_A_USTK_HI)
			begin
				ustk_hi_d = PWDATA_IN[`DXD_TADDR_W-1:0];
			end
			else if (PADDR_IN == `DXD_A_ISTK_LO)
			begin
				istk_lo_d = PWDATA_IN[`DXD_TADDR_W-1:0];
			end
			else if (PADDR_IN == `DXD_A_ISTK_HI)
			begin
				istk_hi_d = PWDATA_IN[`DXD_TADDR_W-1:0];
			end
			else if (PADDR_IN[11:8] == `DXD_A_PROT_PAGE)
			begin
				// Allocation of ranges to the sixteen blocks is left to software.
				if (PADDR_IN[3:2] == 2'h0)
				begin
					prot_d[PADDR_IN[7:4]].lo = PWDATA_IN[`DXD_TADDR_W-1:0];
				end
				else if (PADDR_IN[3:2] == 2'h1)
				begin
					prot_d[PADDR_IN[7:4]].hi = PWDATA_IN[`DXD_TADDR_W-1:0];
				end
				else if (PADDR_IN[3:2] == 2'h2)
				begin
					prot_d[PADDR_IN[7:4]].attr = dxd_attr_e'(PWDATA_IN[2:0]);
					prot_d[PADDR_IN[7:4]].en = PWDATA_IN[`DXD_PROT_EN_BIT];
				end
			end
			else if (PADDR_IN[11:7] == `DXD_A_MON_PAGE)
			begin
				// Writing a block's setup restarts its monitoring from an empty history.
				mon_en_d[PADDR_IN[6:2]] = PWDATA_IN[`DXD_MON_EN_BIT];
				mon_base_d[PADDR_IN[6:2]] = {PWDATA_IN[`DXD_TADDR_W-1:`DXD_MON_IDX_MSB+1],
					9'h000};
				written_d[PADDR_IN[6:2]] = '0;
			end
			else if (PADDR_IN[11:7] == `DXD_A_TASK_PAGE)
			begin
				if (PADDR_IN[3:2] == 2'h0)
				begin
					task_d[PADDR_IN[6:4]].tid = PWDATA_IN[`DXD_TID_W-1:0];
					task_d[PADDR_IN[6:4]].en = PWDATA_IN[`DXD_TASK_EN_BIT];
				end
				else if (PADDR_IN[3:2] == 2'h1)
				begin
					task_d[PADDR_IN[6:4]].lo = PWDATA_IN[`DXD_TADDR_W-1:0];
				end
				else if (PADDR_IN[3:2] == 2'h2)
				begin
					task_d[PADDR_IN[6:4]].hi = PWDATA_IN[`DXD_TADDR_W-1:0];
				end
			end
		end
	end

	// Read data is captured in the setup cycle, so the access phase completes at once.
	always_comb
	begin
		prdata_d = prdata_q;
		pslverr_d = pslverr_q;
		if (setup)
		begin
			prdata_d = '0;
			pslverr_d = 1'b0;
			if (PADDR_IN == `DXD_A_CTRL)
			begin
				prdata_d[2:0] = ctrl_q;
			end
			else if (PADDR_IN == `DXD_A_STATUS)
			begin
				prdata_d[`DXD_NEV-1:0] = status_q;
			end
			else if (PADDR_IN == `DXD_A_WARN_EN)
			begin
				prdata_d[`DXD_NEV-1:0] = warn_en_q;
			end
			else if (PADDR_IN == `DXD_A_BRK_EN)
			begin
				prdata_d[`DXD_NEV-1:0] = brk_en_q;
			end
			else if (PADDR_IN == `DXD_A_TRACE_EN)
			begin
				prdata_d[`DXD_NEV-1:0] = trace_en_q;
			end
			else if (PADDR_IN == `DXD_A_PERF)
			begin
				prdata_d[0] = perf_mark_q;
			end
			else if (PADDR_IN == `DXD_A_USTK_LO)
			begin
				prdata_d[`DXD_TADDR_W-1:0] = ustk_lo_q;
			end
			else if (PADDR_IN == `DXD_A_USTK_HI)
			begin
				prdata_d[`DXD_TADDR_W-1:0] = ustk_hi_q;
			end
			else if (PADDR_IN == `DXD_A_ISTK_LO)
			begin
				prdata_d[`DXD_TADDR_W-1:0] = istk_lo_q;
			end
			else if (PADDR_IN == `DXD_A_ISTK_HI)
			begin
				prdata_d[`DXD_TADDR_W-1:0] = istk_hi_q;
			end
			else if (PADDR_IN[11:8] == `DXD_A_PROT_PAGE && PADDR_IN[3:2] != 2'h3)
			begin
				if (PADDR_IN[3:2] == 2'h0)
				begin
					prdata_d[`DXD_TADDR_W-1:0] = prot_q[PADDR_IN[7:4]].lo;
				end
				else if (PADDR_IN[3:2] == 2'h1)
				begin
					prdata_d[`DXD_TADDR_W-1:0] = prot_q[PADDR_IN[7:4]].hi;
				end
				else
				begin
					prdata_d[`DXD_PROT_EN_BIT:0] = {prot_q[PADDR_IN[7:4]].en,
						prot_q[PADDR_IN[7:4]].attr};
				end
			end
			else if (PADDR_IN[11:7] == `DXD_A_MON_PAGE)
			begin
				prdata_d[`DXD_TADDR_W-1:0] = mon_base_q[PADDR_IN[6:2]];
				prdata_d[`DXD_MON_EN_BIT] = mon_en_q[PADDR_IN[6:2]];
			end
			else if (PADDR_IN[11:7] == `DXD_A_TASK_PAGE && PADDR_IN[3:2] != 2'h3)
			begin
				if (PADDR_IN[3:2] == 2'h0)
				begin
					prdata_d[`DXD_TASK_EN_BIT:0] = {task_q[PADDR_IN[6:4]].en,
						task_q[PADDR_IN[6:4]].tid};
				end
				else if (PADDR_IN[3:2] == 2'h1)
				begin
					prdata_d[`DXD_TADDR_W-1:0] = task_q[PADDR_IN[6:4]].lo;
				end
				else
				begin
					prdata_d[`DXD_TADDR_W-1:0] = task_q[PADDR_IN[6:4]].hi;
				end
			end
			else
			begin
				pslverr_d = 1'b1;
			end
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			ctrl_q <= `DXD_CTRL_RESET;
			status_q <= '0;
			warn_en_q <= '0;
			brk_en_q <= '0;
			trace_en_q <= '0;
			ustk_lo_q <= '0;
			ustk_hi_q <= '0;
			istk_lo_q <= '0;
			istk_hi_q <= '0;
			for (int i = 0; i < `DXD_NPROT; i++)
			begin
				prot_q[i] <= '0;
			end
			for (int i = 0; i < `DXD_NTASK; i++)
			begin
				task_q[i] <= '0;
			end
			for (int i = 0; i < `DXD_NMON; i++)
			begin
				mon_base_q[i] <= '0;
				written_q[i] <= '0;
			end
			mon_en_q <= '0;
			perf_cnt_q <= '0;
			perf_mark_q <= 1'b0;
			prof_time_q <= '0;
			prof_pass_q <= '0;
			trace_cnt_q <= '0;
			stk_out_q <= 1'b0;
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			status_q <= status_d;
			warn_en_q <= warn_en_d;
			brk_en_q <= brk_en_d;
			trace_en_q <= trace_en_d;
			ustk_lo_q <= ustk_lo_d;
			ustk_hi_q <= ustk_hi_d;
			istk_lo_q <= istk_lo_d;
			istk_hi_q <= istk_hi_d;
			prot_q <= prot_d;
			task_q <= task_d;
			mon_base_q <= mon_base_d;
			written_q <= written_d;
			mon_en_q <= mon_en_d;
			perf_cnt_q <= perf_cnt_d;
			perf_mark_q <= perf_mark_d;
			prof_time_q <= prof_time_d;
			prof_pass_q <= prof_pass_d;
			trace_cnt_q <= trace_cnt_d;
			stk_out_q <= stk_out_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

endmodule
`default_nettype wire

/* hw/dxd_defines.svh */
`ifndef DXD_DEFINES_SVH
`define DXD_DEFINES_SVH

`define DXD_TADDR_W 24
`define DXD_NPROT 16
`define DXD_NMON 32
`define DXD_MON_WORDS 256
`define DXD_MON_IDX_LSB 1
`define DXD_MON_IDX_MSB 8
`define DXD_MON_SPAN 24'h0001ff
`define DXD_NTASK 8
`define DXD_TID_W 8
`define DXD_NEV 8

`define DXD_EV_PROT 0
`define DXD_EV_UNINIT 1
`define DXD_EV_STACK 2
`define DXD_EV_PERF 3
`define DXD_EV_PROF 4
`define DXD_EV_TRACE 5
`define DXD_EV_TSTACK 6
`define DXD_EV_DISPATCH 7

`define DXD_PERF_MAX 40'hff_ffff_ffff
`define DXD_PROF_TIME_MAX 40'hff_ffff_ffff
`define DXD_PROF_PASS_MAX 16'hffff
`define DXD_TRACE_MAX 22'h3f_ffff
`define DXD_TRACE_EN_MASK 8'hdf

`define DXD_A_CTRL 12'h000
`define DXD_A_STATUS 12'h004
`define DXD_A_WARN_EN 12'h008
`define DXD_A_BRK_EN 12'h00c
`define DXD_A_TRACE_EN 12'h010
`define DXD_A_PERF 12'h014
`define DXD_A_USTK_LO 12'h018
`define DXD_A_USTK_HI 12'h01c
`define DXD_A_ISTK_LO 12'h020
`define DXD_A_ISTK_HI 12'h024
`define DXD_A_PROT_PAGE 4'h1
`define DXD_A_MON_PAGE 5'h04
`define DXD_A_TASK_PAGE 5'h06

`define DXD_CTRL_ARM 0
`define DXD_CTRL_OS 1
`define DXD_CTRL_RESET 3'h0
`define DXD_PROT_EN_BIT 3
`define DXD_TASK_EN_BIT 8
`define DXD_MON_EN_BIT 0

`endif

/* hw/dxd_pkg.sv */
`default_nettype none
`include "dxd_defines.svh"

package dxd_pkg;

	typedef enum logic [2:0] {
		DXD_ATTR_RW = 3'h0,
		DXD_ATTR_RO = 3'h1,
		DXD_ATTR_WO = 3'h2,
		DXD_ATTR_DIS = 3'h3,
		DXD_ATTR_DIS_OS = 3'h4
	} dxd_attr_e;

	typedef logic [`DXD_TADDR_W-1:0] dxd_addr_t;

	typedef struct packed {
		dxd_addr_t addr;
		logic rd;
		logic wr;
		logic fetch;
		logic os;
		logic [`DXD_TID_W-1:0] task_id;
	} dxd_tacc_s;

	typedef struct packed {
		logic en;
		dxd_attr_e attr;
		dxd_addr_t lo;
		dxd_addr_t hi;
	} dxd_prot_s;

	typedef struct packed {
		logic en;
		logic [`DXD_TID_W-1:0] tid;
		dxd_addr_t lo;
		dxd_addr_t hi;
	} dxd_task_s;

	typedef struct packed {
		logic irq_entry;
		logic irq_return;
		logic call;
		logic ret;
	} dxd_stk_evt_s;

endpackage
`default_nettype wire

/* sim/dxd_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module dxd_chk
	import dxd_pkg::*;
(
	input wire logic CLOCK_IN,
	input wire logic RSTN_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire logic WARN_OUT,
	input wire logic BRK_COND_OUT,
	input wire logic TRACE_COND_OUT
);
	logic wr;
	logic [7:0] brk_q, brk_d, trc_q, trc_d;
	assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
	// Shadow masks let a condition pulse be traced back to an enable bit.
	always_comb
	begin
		brk_d = brk_q;
		trc_d = trc_q;
		if (wr && PADDR_IN == 12'h00c)
			brk_d = PWDATA_IN[7:0];
		if (wr && PADDR_IN == 12'h010)
			trc_d = PWDATA_IN[7:0] & 8'hdf;
	end
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			brk_q <= 8'h00;
			trc_q <= 8'h00;
		end
		else
		begin
			brk_q <= brk_d;
			trc_q <= trc_d;
		end
	end
	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (!RSTN_IN);
	sequence setup_s;
		PSEL_IN && !PENABLE_IN;
	endsequence
	sequence access_s;
		PSEL_IN && PENABLE_IN;
	endsequence
	ready_now_a: assert property (setup_s ##1 access_s |-> PREADY_OUT)
		else $error("access phase without ready");
	ready_only_a: assert property (PREADY_OUT |-> PSEL_IN && PENABLE_IN)
		else $error("ready outside access phase");
	err_phase_a: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN)
		else $error("error flag outside access phase");
	// The top page of the map holds no register, so every access there must be refused.
	err_map_a: assert property (setup_s ##1 (access_s && PADDR_IN[11:8] == 4'hf) |-> PSLVERR_OUT)
		else $error("unmapped access not refused");
	rdata_hold_a: assert property ($changed(PRDATA_OUT) |-> $past(PSEL_IN) && !$past(PENABLE_IN))
		else $error("read data moved without setup");
	quiet_start_a: assert property ($rose(RSTN_IN) |-> !(WARN_OUT || BRK_COND_OUT || TRACE_COND_OUT))
		else $error("flags active after reset");
	warn_sticky_a: assert property (WARN_OUT && !wr |=> WARN_OUT)
		else $error("warning dropped without write");
	brk_mask_a: assert property (BRK_COND_OUT |-> brk_q != 8'h00)
		else $error("breakpoint with no enable");
	trc_mask_a: assert property (TRACE_COND_OUT |-> trc_q != 8'h00)
		else $error("trace point with no enable");
endmodule
`default_nettype wire

/* sim/dxd_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dxd_core_model
	import dxd_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic req_in,
	input wire dxd_tacc_s acc_in,
	input wire logic slow_in,
	output dxd_tacc_s tbus_out,
	output logic ack_out
);
	logic [1:0] st, cnt;
	// Strobes last one cycle; between accesses the address bus shows a changing pattern.
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			tbus_out <= '0;
			ack_out <= 1'b0;
			st <= 2'd0;
			cnt <= 2'd0;
		end
		else
		begin
			ack_out <= 1'b0;
			tbus_out <= {~tbus_out.addr, 4'h0, tbus_out.task_id};
			case (st)
			2'd0: if (req_in)
			begin
				cnt <= slow_in ? 2'd3 : 2'd0;
				st <= 2'd1;
			end
			2'd1: if (cnt != 2'd0)
				cnt <= cnt - 2'd1;
			else
			begin
				tbus_out <= acc_in;
				ack_out <= 1'b1;
				st <= 2'd2;
			end
			default: if (!req_in)
				st <= 2'd0;
			endcase
		end
	end
endmodule
`default_nettype wire

/* sim/dxd_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CK(g, e) \
	begin \
		samples_checked++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e); \
		end \
	end
module dxd_top_tb
	import dxd_pkg::*;
();
	logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, warn, brk, trc, ack, req = 1'b0, slow = 1'b0, disp = 1'b0;
	logic pass = 1'b0, zero = 1'b0;
	dxd_addr_t user_stack_pointer = 24'h001800, interrupt_stack_pointer = 24'h002800;
	dxd_stk_evt_s sev = '0;
	dxd_tacc_s acc = '0, tbus;
	int n_mismatch = 0, samples_checked = 0, cyc = 0;
	int a, k, o;
	logic v;
	dxd_top u_dut (.CLOCK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TBUS_IN(tbus),
		.USER_STACK_POINTER_IN(user_stack_pointer), .INTERRUPT_STACK_POINTER_IN(interrupt_stack_pointer),
		.STACK_EVT_IN(sev), .DISPATCH_IN(disp), .PERF_START_IN(zero), .PERF_RUN_IN(zero),
		.PROF_RUN_IN(zero), .PROF_PASS_IN(pass), .TRACE_STORE_IN(zero), .WARN_OUT(warn),
		.BRK_COND_OUT(brk), .TRACE_COND_OUT(trc));
	dxd_core_model u_core (.clk_in(clk), .rstn_in(rstn), .req_in(req), .acc_in(acc),
		.slow_in(slow), .tbus_out(tbus), .ack_out(ack));
	initial
	begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
		output logic [32:0] r);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = {pslverr, prdata};
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		logic [32:0] r;
		apb(1'b1, ad, d, r);
	endtask
	task automatic rd(input logic [11:0] ad, input logic e, input logic [31:0] x);
		logic [32:0] r;
		apb(1'b0, ad, 32'h0, r);
		`CK(r, {e, x})
	endtask
	function automatic dxd_tacc_s mk(input dxd_addr_t ad, input int t, input logic s,
		input logic [7:0] id);
		return {ad, t == 0, t == 1, t == 2, s, id};
	endfunction
	task automatic core(input dxd_tacc_s c, input logic [1:0] x);
		acc <= c;
		req <= 1'b1;
		do @(negedge clk); while (ack !== 1'b1);
		`CK({brk, trc}, x)
		@(posedge clk);
		req <= 1'b0;
		@(posedge clk);
	endtask
	task automatic pulse(input dxd_stk_evt_s s, input logic d, input logic [1:0] x);
		sev <= s;
		disp <= d;
		@(negedge clk);
		`CK({brk, trc}, x)
		@(posedge clk);
		sev <= '0;
		disp <= 1'b0;
		@(posedge clk);
	endtask
	task automatic st_chk(input logic [31:0] x);
		rd(12'h004, 1'b0, x);
		`CK(warn, |x)
		wr(12'h004, 32'hff);
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(12'h000, 1'b0, 32'h0);
		rd(12'h004, 1'b0, 32'h0);
		rd(12'h108, 1'b0, 32'h0);
		rd(12'hffc, 1'b1, 32'h0);
		rd(12'h014, 1'b0, 32'h0);
		wr(12'h008, 32'hff);
		wr(12'h00c, 32'hff);
		wr(12'h010, 32'hff);
		rd(12'h010, 1'b0, 32'hdf);
		$display("test reset done");
		wr(12'h1f0, 32'hfffff0);
		wr(12'h1f4, 32'hffffff);
		for (a = 0; a < 5; a++)
			for (k = 0; k < 3; k++)
				for (o = 0; o < 2; o++)
				begin
					if ((a == 1 || a == 2) && k == 2)
						continue;
					v = (a == 1 && k == 1) || (a == 2 && k == 0) || a == 3 || (a == 4 && o == 0);
					wr(12'h1f8, 32'h8 | a);
					core(mk(24'hfffff8, k, o, 8'h0), {v, v});
				end
		rd(12'h1f0, 1'b0, 32'hfffff0);
		wr(12'h1f8, 32'h3);
		core(mk(24'hfffff8, 0, 0, 8'h0), 2'b00);
		core(mk(24'hffffef, 1, 0, 8'h0), 2'b00);
		st_chk(32'h1);
		wr(12'h108, 32'hb);
		wr(12'h104, 32'hf);
		core(mk(24'h000000, 0, 0, 8'h0), 2'b11);
		wr(12'h00c, 32'h1);
		wr(12'h010, 32'h0);
		core(mk(24'h000004, 0, 0, 8'h0), 2'b10);
		wr(12'h00c, 32'h0);
		wr(12'h010, 32'h1);
		core(mk(24'h000004, 0, 0, 8'h0), 2'b01);
		wr(12'h010, 32'h0);
		core(mk(24'h000004, 0, 0, 8'h0), 2'b00);
		st_chk(32'h1);
		wr(12'h00c, 32'hff);
		wr(12'h010, 32'hff);
		$display("test protect done");
		wr(12'h27c, 32'h00004001);
		wr(12'h278, 32'h00006000);
		rd(12'h27c, 1'b0, 32'h00004001);
		core(mk(24'h004010, 0, 0, 8'h0), 2'b11);
		core(mk(24'h004010, 1, 0, 8'h0), 2'b00);
		core(mk(24'h004011, 0, 0, 8'h0), 2'b00);
		core(mk(24'h004012, 0, 0, 8'h0), 2'b11);
		core(mk(24'h0041fe, 0, 0, 8'h0), 2'b11);
		core(mk(24'h004200, 0, 0, 8'h0), 2'b00);
		core(mk(24'h006000, 0, 0, 8'h0), 2'b00);
		st_chk(32'h2);
		$display("test uninit done");
		wr(12'h018, 32'h1000);
		wr(12'h01c, 32'h1fff);
		wr(12'h020, 32'h2000);
		wr(12'h024, 32'h2fff);
		user_stack_pointer <= 24'h003000;
		pulse(4'h2, 1'b0, 2'b00);
		user_stack_pointer <= 24'h001800;
		wr(12'h000, 32'h1);
		user_stack_pointer <= 24'h000fff;
		@(negedge clk);
		`CK(brk, 1'b1)
		@(negedge clk);
		`CK(brk, 1'b0)
		@(posedge clk);
		for (k = 0; k < 4; k++)
			pulse(4'h1 << k, 1'b0, 2'b11);
		user_stack_pointer <= 24'h001fff;
		pulse(4'h2, 1'b0, 2'b00);
		core(mk(24'h001800, 1, 0, 8'h0), 2'b00);
		interrupt_stack_pointer <= 24'h003000;
		pulse(4'h1, 1'b0, 2'b11);
		interrupt_stack_pointer <= 24'h002800;
		st_chk(32'h4);
		$display("test stack done");
		slow <= 1'b1;
		wr(12'h300, 32'h105);
		wr(12'h304, 32'h8000);
		wr(12'h308, 32'h80ff);
		rd(12'h300, 1'b0, 32'h105);
		core(mk(24'h008010, 1, 0, 8'h3), 2'b00);
		pulse(4'h0, 1'b1, 2'b00);
		wr(12'h000, 32'h3);
		core(mk(24'h008010, 1, 0, 8'h3), 2'b11);
		core(mk(24'h008010, 1, 0, 8'h5), 2'b00);
		core(mk(24'h008010, 0, 0, 8'h3), 2'b00);
		core(mk(24'h008100, 1, 0, 8'h3), 2'b00);
		pulse(4'h0, 1'b1, 2'b11);
		rd(12'h004, 1'b0, 32'hc0);
		wr(12'h004, 32'h40);
		rd(12'h004, 1'b0, 32'h80);
		st_chk(32'h80);
		$display("test os done");
		pass <= 1'b1;
		repeat (65534) @(posedge clk);
		@(negedge clk);
		`CK(brk, 1'b0)
		@(negedge clk);
		`CK(brk, 1'b1)
		@(posedge clk);
		pass <= 1'b0;
		@(posedge clk);
		st_chk(32'h10);
		$display("test profile done");
		test_done();
	end
endmodule
bind dxd_top dxd_chk u_chk (.CLOCK_IN(CLOCK_IN), .RSTN_IN(RSTN_IN), .PSEL_IN(PSEL_IN),
	.PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
	.PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .WARN_OUT(WARN_OUT), .BRK_COND_OUT(BRK_COND_OUT),
	.TRACE_COND_OUT(TRACE_COND_OUT));
`default_nettype wire
